// File: hdl/cst_defs.vh
`ifndef CST_DEFS_VH
`define CST_DEFS_VH

// ********************************
// Register offsets (byte addresses)
// ********************************
`define CST_OFF_CTRL        8'h00
`define CST_OFF_STATUS      8'h04
`define CST_OFF_BUF_SEL     8'h08
`define CST_OFF_INT_STATUS  8'h0C
`define CST_OFF_INT_CLEAR   8'h10
`define CST_OFF_INT_EN      8'h14
`define CST_OFF_BCTL_BASE   8'h18
`define CST_OFF_MSG_BASE    8'h30

// ********************************
// Operating mode codes
// ********************************
`define CST_MODE_NORMAL     3'h0
`define CST_MODE_SLEEP      3'h1
`define CST_MODE_LOOPBACK   3'h2
`define CST_MODE_LISTEN     3'h3
`define CST_MODE_CONFIG     3'h4
`define CST_MODE_RESET      3'h4

// ********************************
// Interrupt source codes
// ********************************
`define CST_CODE_NONE       5'h00
`define CST_CODE_BUS_ERR    5'h02
`define CST_CODE_TXB2       5'h04
`define CST_CODE_TXB1       5'h06
`define CST_CODE_TXB0       5'h08
`define CST_CODE_RX_ENH     5'h10
`define CST_CODE_PBUF_BASE  5'h12

// ********************************
// Field positions
// ********************************
`define CST_BCTL_DONE       7
`define CST_BCTL_ABT        6
`define CST_BCTL_ARB        5
`define CST_BCTL_ERR        4
`define CST_BCTL_REQ        3
`define CST_BCTL_RTR        2
`define CST_INT_BUS_ERR     0
`define CST_INT_TXB0        1
`define CST_INT_PBUF0       4
`define CST_INT_WIDTH       10

`endif

// File: hdl/cst_tx_arbiter.v
`timescale 1ns/1ps
module cst_tx_arbiter #(
	parameter NBUF = 6
) (
	pending,
	prio,
	found,
	idx
);
	input  wire [NBUF-1:0]   pending;
	input  wire [2*NBUF-1:0] prio;
	output reg               found;
	output reg  [2:0]        idx;

	integer    i;
	reg  [1:0] best;

	// Higher level wins; on a tie the higher buffer index wins
	always @*
	begin
		found = 1'b0;
		idx   = 3'h0;
		best  = 2'h0;
		for (i = 0; i < NBUF; i = i + 1)
		begin
			if (pending[i] && (!found || prio[2*i +: 2] >= best))
			begin
				found = 1'b1;
				idx   = i[2:0];
				best  = prio[2*i +: 2];
			end
		end
	end
endmodule // cst_tx_arbiter

// File: hdl/cst_irq_code.v
`timescale 1ns/1ps
`include "cst_defs.vh"
module cst_irq_code (
	active,
	enhanced,
	buf_is_tx,
	code
);
	input  wire [`CST_INT_WIDTH-1:0] active;
	input  wire                      enhanced;
	input  wire [5:0]                buf_is_tx;
	output reg  [4:0]                code;

	integer i;

	// Loop runs lowest priority first so the last hit is the winner
	always @*
	begin
		code = `CST_CODE_NONE;
		if (enhanced)
		begin
			for (i = 5; i >= 0; i = i - 1)
			begin
				if (active[`CST_INT_PBUF0 + i])
					code = buf_is_tx[i] ? (`CST_CODE_PBUF_BASE + i[4:0]) : `CST_CODE_RX_ENH;
			end
		end
		if (active[`CST_INT_TXB0])
			code = `CST_CODE_TXB0;
		if (active[`CST_INT_TXB0 + 1])
			code = `CST_CODE_TXB1;
		if (active[`CST_INT_TXB0 + 2])
			code = `CST_CODE_TXB2;
		if (active[`CST_INT_BUS_ERR])
			code = `CST_CODE_BUS_ERR;
	end
endmodule // cst_irq_code

// File: hdl/cst_top.v
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "cst_defs.vh"
module cst_top #(
	parameter NBUF = 6
) (
	pclk,
	presetn,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	eng_tx_ok,
	eng_tx_arb_lost,
	eng_tx_err,
	eng_tx_aborted,
	eng_bus_err,
	eng_txb_irq,
	eng_rx_irq,
	eng_rtr_hit,
	eng_tx_start,
	eng_tx_buf,
	eng_tx_msg,
	eng_abort_req,
	eng_op_mode,
	irq
);
	input  wire        pclk;
	input  wire        presetn;
	input  wire        psel;
	input  wire        penable;
	input  wire        pwrite;
	input  wire [7:0]  paddr;
	input  wire [31:0] pwdata;
	output reg  [31:0] prdata;
	output reg         pready;
	output reg         pslverr;
	input  wire        eng_tx_ok;
	input  wire        eng_tx_arb_lost;
	input  wire        eng_tx_err;
	input  wire        eng_tx_aborted;
	input  wire        eng_bus_err;
	input  wire [2:0]  eng_txb_irq;
	input  wire [5:0]  eng_rx_irq;
	input  wire [5:0]  eng_rtr_hit;
	output reg         eng_tx_start;
	output reg  [2:0]  eng_tx_buf;
	output reg  [31:0] eng_tx_msg;
	output reg         eng_abort_req;
	output reg  [2:0]  eng_op_mode;
	output reg         irq;

	localparam ST_IDLE = 1'b0;
	localparam ST_SEND = 1'b1;

	// ********************************
	// State
	// ********************************
	reg  [2:0]                mode_req_reg;
	reg  [1:0]                func_mode_reg;
	reg  [5:0]                tx_sel_reg;
	reg  [`CST_INT_WIDTH-1:0] int_status_reg;
	reg  [`CST_INT_WIDTH-1:0] int_status_next;
	reg  [`CST_INT_WIDTH-1:0] int_en_reg;
	reg  [5:0]                done_reg;
	reg  [5:0]                abt_reg;
	reg  [5:0]                arb_reg;
	reg  [5:0]                err_reg;
	reg  [5:0]                req_reg;
	reg  [5:0]                rtr_reg;
	reg  [11:0]               pri_reg;
	reg  [5:0]                done_next;
	reg  [5:0]                abt_next;
	reg  [5:0]                arb_next;
	reg  [5:0]                err_next;
	reg  [5:0]                req_next;
	reg  [31:0]               msg_reg [0:5];
	reg                       state_reg;
	reg  [2:0]                cur_reg;
	reg  [31:0]               rdata_next;
	reg                       rerr_next;
	reg  [2:0]                rd_buf;
	integer                   n;
	integer                   k;

	wire        wr_en     = psel & penable & pready & pwrite;
	wire        setup     = psel & ~penable;
	wire        enhanced  = (func_mode_reg != 2'h0);
	wire [5:0]  pend      = req_reg & tx_sel_reg & {6{enhanced}};
	wire        can_send  = (eng_op_mode == `CST_MODE_NORMAL) || (eng_op_mode == `CST_MODE_LOOPBACK);
	wire        arb_found;
	wire [2:0]  arb_idx;
	wire [4:0]  irq_code;
	wire        in_send   = (state_reg == ST_SEND);

	// ********************************
	// Address decode helpers
	// ********************************
	function is_bctl;
		input [7:0] a;
		begin
			is_bctl = (a >= `CST_OFF_BCTL_BASE) && (a < `CST_OFF_MSG_BASE) && (a[1:0] == 2'h0);
		end
	endfunction

	function is_msg;
		input [7:0] a;
		begin
			is_msg = (a >= `CST_OFF_MSG_BASE) && (a < (`CST_OFF_MSG_BASE + 8'h18)) && (a[1:0] == 2'h0);
		end
	endfunction

	function [2:0] buf_of;
		input [7:0] a;
		input [7:0] base;
		reg   [7:0] d;
		begin
			d      = a - base;
			buf_of = d[4:2];
		end
	endfunction

	cst_tx_arbiter #(
		.NBUF (NBUF)
	) u_arb (
		.pending (pend),
		.prio    (pri_reg),
		.found   (arb_found),
		.idx     (arb_idx)
	);

	cst_irq_code u_code (
		.active    (int_status_reg & int_en_reg),
		.enhanced  (enhanced),
		.buf_is_tx (tx_sel_reg),
		.code      (irq_code)
	);

	// ********************************
	// Read mux
	// ********************************
	always @*
	begin
		rdata_next = 32'h0000_0000;
		rerr_next  = 1'b0;
		rd_buf     = 3'h0;
		case (paddr)
			`CST_OFF_CTRL:       rdata_next = {26'h0, func_mode_reg, 1'b0, mode_req_reg};
			`CST_OFF_STATUS:     rdata_next = {24'h0, eng_op_mode, irq_code};
			`CST_OFF_BUF_SEL:    rdata_next = {26'h0, tx_sel_reg};
			`CST_OFF_INT_STATUS: rdata_next = {22'h0, int_status_reg};
			`CST_OFF_INT_CLEAR:  rdata_next = 32'h0000_0000;
			`CST_OFF_INT_EN:     rdata_next = {22'h0, int_en_reg};
			default:
			begin
				if (is_bctl(paddr))
				begin
					rd_buf = buf_of(paddr, `CST_OFF_BCTL_BASE);
					// Receive-mode layout is not held here, so it reads as zero
					if (enhanced && tx_sel_reg[rd_buf])
						rdata_next = {24'h0, done_reg[rd_buf], abt_reg[rd_buf], arb_reg[rd_buf], err_reg[rd_buf],
							req_reg[rd_buf], rtr_reg[rd_buf], pri_reg[2*rd_buf +: 2]};
				end
				else if (is_msg(paddr))
					rdata_next = msg_reg[buf_of(paddr, `CST_OFF_MSG_BASE)];
				else
					rerr_next = 1'b1;
			end
		endcase
	end

	// ********************************
	// Buffer control next state
	// ********************************
	always @*
	begin
		done_next = done_reg;
		abt_next  = abt_reg;
		arb_next  = arb_reg;
		err_next  = err_reg;
		req_next  = req_reg;
		for (n = 0; n < NBUF; n = n + 1)
		begin
			// Software side first so hardware events below win over it
			if (wr_en && is_bctl(paddr) && buf_of(paddr, `CST_OFF_BCTL_BASE) == n
				&& enhanced && tx_sel_reg[n])
			begin
				if (pwdata[`CST_BCTL_REQ] && !req_reg[n])
				begin
					req_next[n]  = 1'b1;
					done_next[n] = 1'b0;
					abt_next[n]  = 1'b0;
					arb_next[n]  = 1'b0;
					err_next[n]  = 1'b0;
				end
				else if (!pwdata[`CST_BCTL_REQ] && req_reg[n])
				begin
					req_next[n] = 1'b0;
					if (!(in_send && cur_reg == n))
						abt_next[n] = 1'b1;
				end
			end
			if (eng_rtr_hit[n] && rtr_reg[n] && tx_sel_reg[n] && !req_reg[n])
			begin
				req_next[n]  = 1'b1;
				done_next[n] = 1'b0;
				abt_next[n]  = 1'b0;
				arb_next[n]  = 1'b0;
				err_next[n]  = 1'b0;
			end
			if (in_send && cur_reg == n)
			begin
				if (eng_tx_ok)
				begin
					done_next[n] = 1'b1;
					req_next[n]  = 1'b0;
				end
				if (eng_tx_aborted)
				begin
					abt_next[n] = 1'b1;
					req_next[n] = 1'b0;
				end
				if (eng_tx_arb_lost)
					arb_next[n] = 1'b1;
				if (eng_tx_err)
					err_next[n] = 1'b1;
			end
		end
	end

	// ********************************
	// Interrupt status next state
	// ********************************
	always @*
	begin
		int_status_next = int_status_reg;
		if (wr_en && paddr == `CST_OFF_INT_CLEAR)
			int_status_next = int_status_reg & ~pwdata[`CST_INT_WIDTH-1:0];
		// Sets are applied after the clear so a coincident event is kept
		int_status_next[`CST_INT_BUS_ERR] = int_status_next[`CST_INT_BUS_ERR] | eng_bus_err
			| (in_send & eng_tx_err);
		int_status_next[`CST_INT_TXB0 +: 3] = int_status_next[`CST_INT_TXB0 +: 3] | eng_txb_irq;
		int_status_next[`CST_INT_PBUF0 +: 6] = int_status_next[`CST_INT_PBUF0 +: 6]
			| (done_next & ~done_reg) | (eng_rx_irq & ~tx_sel_reg);
	end

	// ********************************
	// Registers and bus response
	// ********************************
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata         <= 32'h0000_0000;
			pready         <= 1'b0;
			pslverr        <= 1'b0;
			mode_req_reg   <= `CST_MODE_RESET;
			func_mode_reg  <= 2'h0;
			tx_sel_reg     <= 6'h00;
			int_status_reg <= {`CST_INT_WIDTH{1'b0}};
			int_en_reg     <= {`CST_INT_WIDTH{1'b0}};
			done_reg       <= 6'h00;
			abt_reg        <= 6'h00;
			arb_reg        <= 6'h00;
			err_reg        <= 6'h00;
			req_reg        <= 6'h00;
			rtr_reg        <= 6'h00;
			pri_reg        <= 12'h000;
			irq            <= 1'b0;
			for (k = 0; k < NBUF; k = k + 1)
				msg_reg[k] <= 32'h0000_0000;
		end
		else
		begin
			// Answer is prepared in the setup cycle: zero wait states
			pready  <= setup;
			pslverr <= setup & rerr_next;
			if (setup && !pwrite)
				prdata <= rdata_next;
			if (wr_en && !pslverr)
			begin
				if (paddr == `CST_OFF_CTRL)
				begin
					// Reserved mode codes are ignored rather than stored
					if (pwdata[2:0] <= `CST_MODE_CONFIG)
						mode_req_reg <= pwdata[2:0];
					if (pwdata[5:4] != 2'h3)
						func_mode_reg <= pwdata[5:4];
				end
				if (paddr == `CST_OFF_BUF_SEL)
					tx_sel_reg <= pwdata[5:0];
				if (paddr == `CST_OFF_INT_EN)
					int_en_reg <= pwdata[`CST_INT_WIDTH-1:0];
				if (is_bctl(paddr) && enhanced && tx_sel_reg[buf_of(paddr, `CST_OFF_BCTL_BASE)])
				begin
					rtr_reg[buf_of(paddr, `CST_OFF_BCTL_BASE)] <= pwdata[`CST_BCTL_RTR];
					pri_reg[2*buf_of(paddr, `CST_OFF_BCTL_BASE) +: 2] <= pwdata[1:0];
				end
				// Writes to a buffer that is queued or on the wire are dropped
				if (is_msg(paddr) && !req_reg[buf_of(paddr, `CST_OFF_MSG_BASE)]
					&& !(in_send && cur_reg == buf_of(paddr, `CST_OFF_MSG_BASE)))
					msg_reg[buf_of(paddr, `CST_OFF_MSG_BASE)] <= pwdata;
			end
			done_reg       <= done_next;
			abt_reg        <= abt_next;
			arb_reg        <= arb_next;
			err_reg        <= err_next;
			req_reg        <= req_next;
			int_status_reg <= int_status_next;
			irq            <= |(int_status_next & int_en_reg);
		end
	end

	// ********************************
	// Transmit sequencer
	// ********************************
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg     <= ST_IDLE;
			cur_reg       <= 3'h0;
			eng_tx_start  <= 1'b0;
			eng_tx_buf    <= 3'h0;
			eng_tx_msg    <= 32'h0000_0000;
			eng_abort_req <= 1'b0;
			eng_op_mode   <= `CST_MODE_RESET;
		end
		else
		begin
			eng_tx_start <= 1'b0;
			// Mode changes wait for the wire to go idle so no frame is cut
			if (state_reg == ST_IDLE)
				eng_op_mode <= mode_req_reg;
			case (state_reg)
				ST_IDLE:
				begin
					eng_abort_req <= 1'b0;
					if (arb_found && can_send && eng_op_mode == mode_req_reg)
					begin
						state_reg    <= ST_SEND;
						cur_reg      <= arb_idx;
						eng_tx_start <= 1'b1;
						eng_tx_buf   <= arb_idx;
						// Message goes out untouched; priority only picked it
						eng_tx_msg   <= msg_reg[arb_idx];
					end
				end
				ST_SEND:
				begin
					eng_abort_req <= ~req_reg[cur_reg];
					if (eng_tx_ok || eng_tx_aborted || eng_tx_arb_lost || eng_tx_err)
					begin
						state_reg     <= ST_IDLE;
						eng_abort_req <= 1'b0;
					end
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule // cst_top

// File: dv/cst_properties.sv
`timescale 1ns/1ps
module cst_properties (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic        eng_tx_ok,
	input wire logic        eng_tx_err,
	input wire logic        eng_bus_err,
	input wire logic [2:0]  eng_txb_irq,
	input wire logic [5:0]  eng_rx_irq,
	input wire logic        eng_tx_start,
	input wire logic [2:0]  eng_tx_buf,
	input wire logic [31:0] eng_tx_msg,
	input wire logic        eng_abort_req,
	input wire logic [2:0]  eng_op_mode,
	input wire logic        irq
);
	// ********************************
	// Bus and engine link checks
	// ********************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Superset of what may set a status bit or unmask one
	wire cause = eng_bus_err | eng_tx_err | eng_tx_ok | (|eng_txb_irq) | (|eng_rx_irq) | (psel & penable & pwrite);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_commit;
		psel && penable && pwrite && pready;
	endsequence
	chk_ready_once: assert property (s_setup |=> pready ##1 !pready)
		else $error("ready not one cycle after setup");
	chk_mode_legal: assert property (eng_op_mode <= 3'h4)
		else $error("reserved mode code");
	chk_start_mode: assert property (eng_tx_start |-> eng_op_mode == 3'h0 || eng_op_mode == 3'h2)
		else $error("frame started outside normal or loopback");
	chk_start_pulse: assert property (eng_tx_start |=> !eng_tx_start)
		else $error("start longer than one cycle");
	chk_buf_hold: assert property ($changed(eng_tx_buf) |-> eng_tx_start)
		else $error("buffer index moved without start");
	chk_msg_hold: assert property ($changed(eng_tx_msg) |-> eng_tx_start)
		else $error("message moved without start");
	// Commit edge, then the sequencer reacts one edge later
	chk_abort_cause: assert property ($rose(eng_abort_req) |-> $past(psel && penable && pwrite && pready, 2))
		else $error("abort without write");
	// Engine pulses reach irq one edge later, enable writes two
	chk_irq_cause: assert property ($rose(irq) |-> $past(cause) || $past(cause, 2))
		else $error("irq rose without event");
	cover property (s_commit);
endmodule // cst_properties
bind cst_top cst_properties CHK (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .eng_tx_ok, .eng_tx_err,
	.eng_bus_err, .eng_txb_irq, .eng_rx_irq, .eng_tx_start, .eng_tx_buf, .eng_tx_msg, .eng_abort_req, .eng_op_mode, .irq);

// File: dv/cst_engine_model.sv
`timescale 1ns/1ps
// ********************************
// Bus side stand-in
// ********************************
module cst_engine_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       eng_tx_start,
	input  wire logic       eng_abort_req,
	input  wire logic [7:0] dly,
	input  wire logic [1:0] kind,
	output logic            eng_tx_ok,
	output logic            eng_tx_arb_lost,
	output logic            eng_tx_err,
	output logic            eng_tx_aborted
);
	logic       busy_reg;
	logic [7:0] cnt_reg;
	logic [1:0] kind_reg;
	// Outcome kind is latched at start so the bench may change it mid-frame
	always @(posedge pclk or negedge presetn)
	begin
		{eng_tx_ok, eng_tx_arb_lost, eng_tx_err, eng_tx_aborted} <= 4'h0;
		if (!presetn)
		begin
			busy_reg <= 1'b0;
			cnt_reg <= 8'h00;
			kind_reg <= 2'h0;
		end
		else if (eng_tx_start)
		begin
			busy_reg <= 1'b1;
			cnt_reg <= dly;
			kind_reg <= kind;
		end
		else if (busy_reg && cnt_reg != 8'h00)
			cnt_reg <= cnt_reg - 8'h01;
		else if (busy_reg)
		begin
			busy_reg <= 1'b0;
			if (eng_abort_req)
				eng_tx_aborted <= 1'b1;
			else
				{eng_tx_ok, eng_tx_arb_lost, eng_tx_err} <= 3'b100 >> kind_reg;
		end
	end
endmodule // cst_engine_model

// File: dv/test_can_status_and_tx_buffer_control.sv
`timescale 1ns/1ps
`include "cst_defs.vh"
`define CHK(got, exp) \
	begin \
		compares++; \
		if ((got) !== (exp)) \
		begin \
			error_cnt++; \
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
		end \
	end
module test_can_status_and_tx_buffer_control;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [15:0] ev = 16'h0;
	logic [7:0]  dly = 8'h03;
	logic [1:0]  kind = 2'h0;
	logic [31:0] rdata;
	logic        serr;
	wire  [31:0] prdata, eng_tx_msg;
	wire  [2:0]  eng_tx_buf, eng_op_mode, eng_txb_irq;
	wire  [5:0]  eng_rx_irq, eng_rtr_hit;
	wire         pready, pslverr, eng_tx_ok, eng_tx_arb_lost, eng_tx_err, eng_tx_aborted;
	wire         eng_tx_start, eng_abort_req, irq, eng_bus_err;
	int          error_cnt = 0;
	int          compares = 0;
	assign {eng_bus_err, eng_txb_irq, eng_rx_irq, eng_rtr_hit} = ev;
	always #25 pclk = ~pclk;
	cst_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.eng_tx_ok, .eng_tx_arb_lost, .eng_tx_err, .eng_tx_aborted, .eng_bus_err, .eng_txb_irq, .eng_rx_irq,
		.eng_rtr_hit, .eng_tx_start, .eng_tx_buf, .eng_tx_msg, .eng_abort_req, .eng_op_mode, .irq);
	cst_engine_model ENG (.pclk, .presetn, .eng_tx_start, .eng_abort_req, .dly, .kind, .eng_tx_ok,
		.eng_tx_arb_lost, .eng_tx_err, .eng_tx_aborted);
	// ********************************
	// Bus tasks
	// ********************************
	function logic [7:0] bc(int n);
		return `CST_OFF_BCTL_BASE + 8'(4 * n);
	endfunction
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1 && ++n < 20);
		rdata = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rdata, e)
	endtask
	task wait_start(input logic [2:0] b);
		int n;
		n = 0;
		do
			@(posedge pclk);
		while (eng_tx_start !== 1'b1 && ++n < 60);
		`CHK(eng_tx_buf, b)
		`CHK(eng_tx_msg, 32'hC0DE_0000 + b)
	endtask
	// ********************************
	// Scenarios
	// ********************************
	task t_reset;
		rd(`CST_OFF_STATUS, 32'h80);
		`CHK(eng_op_mode, `CST_MODE_CONFIG)
		rd(`CST_OFF_INT_EN, 32'h0);
		apb(1'b0, 8'hFC, 32'h0);
		`CHK(serr, 1'b1)
	endtask
	task t_modes;
		for (int i = 4; i >= 0; i--)
		begin
			// Sleep is visited as software would before a device sleep
			wr(`CST_OFF_CTRL, 32'h10 | i);
			rd(`CST_OFF_STATUS, 32'(i) << 5);
			`CHK(eng_op_mode, 3'(i))
		end
		wr(`CST_OFF_CTRL, 32'h15);
		rd(`CST_OFF_STATUS, 32'h0);
	endtask
	task t_irq;
		logic [9:0] clr [5] = '{10'h001, 10'h008, 10'h004, 10'h002, 10'h020};
		logic [4:0] code [5] = '{5'h04, 5'h06, 5'h08, 5'h10, 5'h00};
		wr(`CST_OFF_INT_EN, 32'h3FF);
		ev <= 16'hF080;
		@(posedge pclk);
		ev <= 16'h0;
		rd(`CST_OFF_STATUS, 32'h02);
		`CHK(irq, 1'b1)
		for (int i = 0; i < 5; i++)
		begin
			wr(`CST_OFF_INT_CLEAR, 32'(clr[i]));
			rd(`CST_OFF_STATUS, 32'(code[i]));
		end
		`CHK(irq, 1'b0)
		wr(`CST_OFF_INT_EN, 32'h0);
		ev <= 16'h8000;
		@(posedge pclk);
		ev <= 16'h0;
		rd(`CST_OFF_STATUS, 32'h0);
		rd(`CST_OFF_INT_STATUS, 32'h1);
		wr(`CST_OFF_INT_EN, 32'h1);
		rd(`CST_OFF_STATUS, 32'h02);
		`CHK(irq, 1'b1)
		wr(`CST_OFF_INT_CLEAR, 32'h1);
	endtask
	task t_send;
		wr(`CST_OFF_CTRL, 32'h14);
		wr(`CST_OFF_BUF_SEL, 32'h3F);
		for (int n = 0; n < 6; n++)
			wr(`CST_OFF_MSG_BASE + 8'(4 * n), 32'hC0DE_0000 + n);
		wr(bc(2), 32'h0B);
		wr(bc(4), 32'h09);
		wr(bc(5), 32'h0B);
		wr(`CST_OFF_MSG_BASE + 8'h14, 32'hFFFF);
		rd(`CST_OFF_MSG_BASE + 8'h14, 32'hC0DE_0005);
		rd(bc(5), 32'h0B);
		wr(`CST_OFF_CTRL, 32'h10);
		wait_start(3'h5);
		wait_start(3'h2);
		wait_start(3'h4);
		repeat (8) @(posedge pclk);
		rd(bc(5), 32'h83);
		wr(`CST_OFF_INT_EN, 32'h3F0);
		rd(`CST_OFF_STATUS, 32'h14);
		wr(`CST_OFF_BUF_SEL, 32'h0);
		rd(bc(5), 32'h0);
		wr(`CST_OFF_BUF_SEL, 32'h3F);
		wr(`CST_OFF_INT_CLEAR, 32'h3F0);
	endtask
	task t_retry;
		logic [7:0] fl [2] = '{8'h20, 8'h10};
		dly <= 8'h14;
		wr(bc(0), 32'h08);
		wait_start(3'h0);
		wr(bc(0), 32'h0);
		// Request drops at the commit edge, the abort line one edge later
		repeat (2) @(posedge pclk);
		`CHK(eng_abort_req, 1'b1)
		repeat (24) @(posedge pclk);
		`CHK(eng_abort_req, 1'b0)
		rd(bc(0), 32'h40);
		dly <= 8'h03;
		for (int i = 0; i < 2; i++)
		begin
			kind <= 2'(i + 1);
			wr(bc(0), 32'h08);
			wait_start(3'h0);
			kind <= 2'h0;
			wait_start(3'h0);
			repeat (8) @(posedge pclk);
			rd(bc(0), 32'h80 | fl[i]);
		end
		wr(`CST_OFF_INT_CLEAR, 32'h3FF);
	endtask
	task t_remote;
		wr(bc(1), 32'h04);
		wr(bc(3), 32'h0);
		ev <= 16'h000A;
		@(posedge pclk);
		ev <= 16'h0;
		wait_start(3'h1);
		repeat (8) @(posedge pclk);
		rd(bc(1), 32'h84);
		rd(bc(3), 32'h0);
	endtask
	task finish_test;
		if (error_cnt == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_modes();
		t_irq();
		t_send();
		t_retry();
		t_remote();
		finish_test();
	end
	initial
	begin
		#200000;
		error_cnt++;
		finish_test();
	end
endmodule // test_can_status_and_tx_buffer_control
